// ---- hw/mirror_array_pattern_memory.sv ----
/*
 Digital model of the micromirror pattern memory: the cell array, the
 column loader on the double-data-rate pattern bus, the internal mirror
 clocking pulse sequence and a mirror state readout port.
 Assumes all inputs are synchronous to mclk and that the controller
 alone decides when patterns are loaded and applied.
*/
//  Contract
//  - One-bit cell array of 912 columns by 1140 rows, one per mirror.
//  - Columns are written one at a time over a 24-bit DDR bus.
//  - The column being written is selected over a separate serial bus.
//  - Writing cells never moves mirrors; all switch together at a pulse.
//  - A cell holding 1 at the pulse lands its mirror on, positive tilt.
//  - A cell holding 0 at the pulse lands its mirror off, minus 12.
//  - Pulse sequence is generated inside; the controller only starts it.
//  - Ten border mirrors per side have no cells and land off.
//  - Parked active mirrors are unlatched and their angles are uncontrolled; border ones still read landed.
`timescale 1ns/1ps
module mirror_array_pattern_memory
   import mirror_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      ser_sel,
   input  wire logic                      ser_dat,
   input  wire logic [mirror_pkg::BUS_W-1:0] pattern_dq,
   input  wire logic                      pattern_valid,
   input  wire logic                      pulse_req,
   input  wire logic                      park,
   input  wire logic [mirror_pkg::COL_AW-1:0] q_col,
   input  wire logic [mirror_pkg::ROW_AW-1:0] q_row,
   output logic                           col_open_reg,
   output logic                           pulse_busy_reg,
   output logic                           tilt_on_reg,
   output logic                           q_landed_reg,
   output logic                           q_border_reg
);
   import mirror_pkg::*;

   // Cell array and the latched mirror state that the pulse loads.
   logic [COLS-1:0]     cells [ROWS];
   logic [COLS-1:0]     mirror [ROWS];

   logic [COL_AW-1:0]   col_addr;
   logic                col_strobe;
   logic [COL_AW-1:0]   col_reg;
   logic [BEAT_CW-1:0]  beat_reg;
   logic [BUS_W-1:0]    fall_reg;
   logic [3:0]          pulse_cnt_reg;
   logic                landed_reg;
   pulse_state_t        state_reg;
   pulse_state_t        state_next;

   logic [BEAT_W-1:0]   beat_word;
   logic                wr_en;
   logic [ROW_AW-1:0]   row_base;
   logic                q_active;
   logic [ROW_AW-1:0]   q_arow;
   logic [COL_AW-1:0]   q_acol;

   serial_col_rx u_col_rx (
      .mclk           (mclk),
      .sys_rst        (sys_rst),
      .ser_sel        (ser_sel),
      .ser_dat        (ser_dat),
      .col_addr_reg   (col_addr),
      .col_strobe_reg (col_strobe)
   );

   // Falling-edge half of each beat; it carries the lower 24 rows.
   always_ff @(negedge mclk or posedge sys_rst) begin
      if (sys_rst) fall_reg <= '0;
      else         fall_reg <= pattern_dq;
   end

   // Beat assembly and write decode. Beats arriving with no column
   // open are dropped, so a stray strobe cannot corrupt the array.
   assign beat_word = {pattern_dq, fall_reg};
   assign wr_en     = pattern_valid && col_open_reg;
   assign row_base  = ROW_AW'(beat_reg * BEAT_W);

   // Column selection and beat counting for one column load.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         col_reg      <= '0;
         beat_reg     <= '0;
         col_open_reg <= 1'b0;
      end else if (col_strobe) begin
         col_reg      <= col_addr;
         beat_reg     <= '0;
         col_open_reg <= 1'b1;
      end else if (wr_en) begin
         beat_reg <= beat_reg + BEAT_CW'(1);
         if (beat_reg == BEAT_LAST) col_open_reg <= 1'b0;
      end
   end

   // Cell writes: 48 rows of the open column per beat. The last beat
   // is partly beyond the array and its upper bits are discarded.
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         for (int i = 0; i < BEAT_W; i++) begin
            if (row_base + ROW_AW'(i) < ROWS_T)
               cells[row_base + ROW_AW'(i)][col_reg] <= beat_word[i];
         end
      end
   end

   // Pulse sequencer. Requests during a running sequence are ignored;
   // the controller is expected to have finished loading first.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:  if (pulse_req) state_next = ST_PULSE;
         ST_PULSE: if (pulse_cnt_reg == PULSE_LAST) state_next = ST_APPLY;
         ST_APPLY: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg      <= ST_IDLE;
         pulse_cnt_reg  <= '0;
         pulse_busy_reg <= 1'b0;
         landed_reg     <= 1'b0;
      end else begin
         state_reg      <= state_next;
         pulse_busy_reg <= state_next != ST_IDLE;
         pulse_cnt_reg  <= (state_reg == ST_PULSE) ?
                           pulse_cnt_reg + 4'h1 : 4'h0;
         if (park)                        landed_reg <= 1'b0;
         else if (state_reg == ST_APPLY)  landed_reg <= 1'b1;
      end
   end

   // All mirrors take the cell contents in the same cycle; this is the
   // only place the mirror state changes.
   always_ff @(posedge mclk) begin
      if (state_reg == ST_APPLY) mirror <= cells;
   end

   // Readout address decode over the full array including the border.
   assign q_active = q_row >= QROW_LO && q_row < QROW_HI &&
                     q_col >= QCOL_LO && q_col < QCOL_HI;
   assign q_arow   = q_row - QROW_LO;
   assign q_acol   = q_col - QCOL_LO;

   // Border mirrors always read as landed off. Active mirrors read
   // their latched bit gated by landed_reg, so they read 0 while parked.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tilt_on_reg  <= 1'b0;
         q_landed_reg <= 1'b0;
         q_border_reg <= 1'b0;
      end else if (q_active) begin
         tilt_on_reg  <= landed_reg && mirror[q_arow][q_acol];
         q_landed_reg <= landed_reg;
         q_border_reg <= 1'b0;
      end else begin
         tilt_on_reg  <= 1'b0;
         q_landed_reg <= 1'b1;
         q_border_reg <= 1'b1;
      end
   end

   col_accept_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      col_strobe |=> col_open_reg && beat_reg == '0)
      else $error("column strobe did not open a load");

   col_close_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_en && beat_reg == BEAT_LAST && !col_strobe |=> !col_open_reg)
      else $error("column load not closed after last beat");

   cell_write_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_en && beat_reg == '0 && !col_strobe
      |=> cells[0][$past(col_reg)] == $past(fall_reg[0]))
      else $error("first row of column not written");

   mirror_hold_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_reg != ST_APPLY |=> $stable(mirror[0]))
      else $error("mirror state moved without a pulse");

   apply_copy_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_reg == ST_APPLY |=> mirror[0] == $past(cells[0]))
      else $error("pulse did not load cell contents");

   pulse_seq_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_reg == ST_IDLE && pulse_req
      |=> (state_reg == ST_PULSE && pulse_busy_reg)[*4]
          ##1 state_reg == ST_APPLY)
      else $error("pulse sequence length wrong");

   border_off_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !q_active |=> !tilt_on_reg && q_border_reg && q_landed_reg)
      else $error("border mirror not landed off");

   off_zero_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      q_active && !mirror[q_arow][q_acol] |=> !tilt_on_reg)
      else $error("zero cell shown as on");

   park_unlatch_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      park |=> !landed_reg ##1 (q_border_reg || !q_landed_reg))
      else $error("parked array still reported landed");

   beat_drop_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      pattern_valid && !col_open_reg && !col_strobe
      |=> $stable(beat_reg) && !col_open_reg)
      else $error("beat taken with no column open");

   pulse_end_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_reg == ST_APPLY |=> state_reg == ST_IDLE && !pulse_busy_reg)
      else $error("pulse sequence did not end after apply");

   landed_set_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state_reg == ST_APPLY && !park |=> landed_reg)
      else $error("pulse did not land the array");
endmodule

// ---- hw/serial_col_rx.sv ----
/*
 Serial control bus receiver that selects the column being written.
 Assumes ser_sel and ser_dat are synchronous to mclk; one bit is taken
 per clock while ser_sel is high, most significant bit first.
*/
`timescale 1ns/1ps
module serial_col_rx
   import mirror_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      ser_sel,
   input  wire logic                      ser_dat,
   output logic [mirror_pkg::COL_AW-1:0]  col_addr_reg,
   output logic                           col_strobe_reg
);
   logic [COL_AW-1:0] shift_reg;
   logic [3:0]        count_reg;
   logic              sel_d_reg;
   logic [COL_AW-1:0] shift_next;
   logic              frame_end;
   logic              frame_ok;

   // A frame ends on the falling edge of the select; only complete
   // frames naming an existing column are accepted.
   assign shift_next = {shift_reg[COL_AW-2:0], ser_dat};
   assign frame_end  = sel_d_reg && !ser_sel;
   assign frame_ok   = frame_end && count_reg == FRAME_BITS &&
                       shift_reg <= COL_LAST;

   // Shift and count; a count past the frame length is held so that a
   // long frame is rejected rather than wrapping into a valid one.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= '0;
         count_reg <= '0;
         sel_d_reg <= 1'b0;
      end else begin
         sel_d_reg <= ser_sel;
         if (ser_sel) begin
            shift_reg <= shift_next;
            if (count_reg <= FRAME_BITS) count_reg <= count_reg + 4'h1;
         end else begin
            count_reg <= '0;
         end
      end
   end

   // Address and one-cycle strobe toward the column loader.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         col_addr_reg   <= '0;
         col_strobe_reg <= 1'b0;
      end else begin
         col_strobe_reg <= frame_ok;
         if (frame_ok) col_addr_reg <= shift_reg;
      end
   end
endmodule

// ---- pkg/mirror_pkg.sv ----
/*
 Constants shared by the mirror array pattern memory and its serial
 column-address receiver: array geometry, bus widths and pulse timing.
 Assumes a single 200 MHz clock domain.
*/
package mirror_pkg;
   // Geometry of the addressable array and the fixed border band.
   localparam int COLS      = 912;
   localparam int ROWS      = 1140;
   localparam int BORDER    = 10;
   localparam int COL_AW    = 10;
   localparam int ROW_AW    = 11;
   localparam int FULL_COLS = COLS + 2 * BORDER;
   localparam int FULL_ROWS = ROWS + 2 * BORDER;
   // Typed bounds used by the address comparators.
   localparam logic [COL_AW-1:0] COL_LAST  = COL_AW'(COLS - 1);
   localparam logic [COL_AW-1:0] QCOL_LO   = COL_AW'(BORDER);
   localparam logic [COL_AW-1:0] QCOL_HI   = COL_AW'(BORDER + COLS);
   localparam logic [ROW_AW-1:0] QROW_LO   = ROW_AW'(BORDER);
   localparam logic [ROW_AW-1:0] QROW_HI   = ROW_AW'(BORDER + ROWS);
   localparam logic [ROW_AW-1:0] ROWS_T    = ROW_AW'(ROWS);
   // Pattern bus: 24 pins, two halves per clock, 48 rows per beat.
   localparam int BUS_W     = 24;
   localparam int BEAT_W    = 2 * BUS_W;
   localparam int BEAT_CW   = 5;
   localparam logic [BEAT_CW-1:0] BEAT_LAST =
      BEAT_CW'((ROWS + BEAT_W - 1) / BEAT_W - 1);
   // Serial column frame length in bits.
   localparam logic [3:0] FRAME_BITS = 4'ha;
   // Internal mirror reset pulse sequence length.
   localparam int CLK_PS    = 5000;
   localparam int PULSE_NS  = 20;
   localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYC - 1);

   typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_APPLY} pulse_state_t;
endpackage

// ---- test/ctrl_model.sv ----
/*
 Display controller model: column frames, DDR pattern beats and pulse
 requests. Assumes the bench calls its tasks and mclk runs freely.
*/
`timescale 1ns/1ps
module ctrl_model
   import mirror_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     col_open_reg,
   output logic                          ser_sel,
   output logic                          ser_dat,
   output logic [mirror_pkg::BUS_W-1:0]  pattern_dq,
   output logic                          pattern_valid,
   output logic                          pulse_req,
   output logic                          missed
);
   // Idle levels at time zero.
   initial begin
      ser_sel = 1'b0;
      ser_dat = 1'b0;
      pattern_dq = '0;
      pattern_valid = 1'b0;
      pulse_req = 1'b0;
      missed = 1'b0;
   end

   // Pattern pacing at 200 MHz: shortest spacing between two applied
   // patterns in each mode, and the depth of the burst store.
   localparam int CLK_HZ     = 200000000;
   localparam int STREAM_GAP = (CLK_HZ + 2880 - 1) / 2880;
   localparam int BURST_GAP  = (CLK_HZ + 4220 - 1) / 4220;
   localparam int BURST_MAX  = 48;
   int            cyc_now    = 0;
   int            last_fire  = 0;
   int            fired      = 0;

   // Free-running cycle count; it paces the pulse requests.
   always @(posedge mclk) begin
      cyc_now <= cyc_now + 1;
   end

   // Cell pattern; data is kept in diamond order, not remapped.
   function automatic logic cellv(input int c, input int r, input logic v);
      return ((((c + r) % 3) == 0) ? 1'b1 : 1'b0) ^ v;
   endfunction

   // One half beat of 24 rows; rows past the array are sent as zero.
   function automatic logic [BUS_W-1:0] half(input int c, input int b,
                                            input logic v);
      logic [BUS_W-1:0] w;
      for (int i = 0; i < BUS_W; i++) begin
         w[i] = (b + i < ROWS) ? cellv(c, b + i, v) : 1'b0;
      end
      return w;
   endfunction

   // Frame of n bits, MSB first; data is inverted once released.
   task automatic frame(input int c, input int n);
      @(negedge mclk);
      ser_sel = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         ser_dat = c[i];
         @(negedge mclk);
      end
      ser_sel = 1'b0;
      ser_dat = ~ser_dat;
   endtask

   // Lower half launched at the rising edge, upper at the falling.
   // Each column is one stretch of the 24-bit parallel stream.
   task automatic beats(input int c, input logic v);
      for (int k = 0; k < 24; k++) begin
         @(posedge mclk);
         pattern_dq <= half(c, 48 * k, v);
         @(negedge mclk);
         pattern_dq <= half(c, 48 * k + 24, v);
         pattern_valid <= 1'b1;
      end
      @(posedge mclk);
      pattern_valid <= 1'b0;
      pattern_dq <= ~pattern_dq;
      @(negedge mclk);
   endtask

   // A whole column: frame, bounded wait for the opening, beats.
   task automatic load_col(input int c, input logic v);
      frame(c, 10);
      for (int i = 0; i < 8 && col_open_reg !== 1'b1; i++) begin
         @(negedge mclk);
      end
      if (col_open_reg !== 1'b1) begin
         missed = 1'b1;
      end
      beats(c, v);
   endtask

   // Request held n cycles, paced to the pattern rate of the chosen
   // mode; only the request seen idle counts.
   task automatic fire(input int n, input logic burst);
      int gap;
      gap = burst ? BURST_GAP : STREAM_GAP;
      while (fired > 0 && cyc_now - last_fire < gap) begin
         @(negedge mclk);
      end
      if (burst && fired >= BURST_MAX) begin
         missed = 1'b1;
      end
      @(negedge mclk);
      pulse_req = 1'b1;
      last_fire = cyc_now;
      fired++;
      repeat (n) begin
         @(negedge mclk);
      end
      pulse_req = 1'b0;
   endtask
endmodule

// ---- test/tb.sv ----
/*
 Bench for the mirror pattern memory: loads the array, fires pulses and
 reads mirrors back. Assumes the controller model in ctrl_model.sv.
*/
`timescale 1ns/1ps
module tb;
   import mirror_pkg::*;
   logic              mclk;
   logic              sys_rst;
   logic              ser_sel;
   logic              ser_dat;
   logic [BUS_W-1:0]  pattern_dq;
   logic              pattern_valid;
   logic              pulse_req;
   logic              park;
   logic [COL_AW-1:0] q_col;
   logic [ROW_AW-1:0] q_row;
   logic              col_open_reg;
   logic              pulse_busy_reg;
   logic              tilt_on_reg;
   logic              q_landed_reg;
   logic              q_border_reg;
   logic              missed;
   int                errors;
   int                checked;
   int                cycles;
   int                rows[7] = '{0, 23, 24, 47, 1103, 1104, 1139};
   int                bc[4] = '{9, 922, 500, 931};
   int                br[4] = '{600, 600, 9, 1150};

   mirror_array_pattern_memory DUT (.mclk(mclk), .sys_rst(sys_rst),
      .ser_sel(ser_sel), .ser_dat(ser_dat), .pattern_dq(pattern_dq),
      .pattern_valid(pattern_valid), .pulse_req(pulse_req), .park(park),
      .q_col(q_col), .q_row(q_row), .col_open_reg(col_open_reg),
      .pulse_busy_reg(pulse_busy_reg), .tilt_on_reg(tilt_on_reg),
      .q_landed_reg(q_landed_reg), .q_border_reg(q_border_reg));
   ctrl_model ctrl (.mclk(mclk), .col_open_reg(col_open_reg),
      .ser_sel(ser_sel), .ser_dat(ser_dat), .pattern_dq(pattern_dq),
      .pattern_valid(pattern_valid), .pulse_req(pulse_req),
      .missed(missed));

   // Clock and a hang guard above the full array load plus one
   // burst-paced gap between two patterns.
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input string s, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", s, e, g);
      end
   endtask

   // Query set at a falling edge, answer read one cycle later.
   task automatic q(input int c, input int r, input logic t, input logic l,
                    input logic b);
      q_col = COL_AW'(c);
      q_row = ROW_AW'(r);
      @(negedge mclk);
      chk("tilt_on_reg", t, tilt_on_reg);
      chk("q_landed_reg", l, q_landed_reg);
      chk("q_border_reg", b, q_border_reg);
   endtask

   task automatic arr(input int c, input logic v);
      for (int i = 0; i < 7; i++) begin
         q(c + BORDER, rows[i] + BORDER, ctrl.cellv(c, rows[i], v),
           1'b1, 1'b0);
      end
   endtask

   task automatic border_chk;
      for (int i = 0; i < 4; i++) begin
         q(bc[i], br[i], 1'b0, 1'b1, 1'b1);
      end
   endtask

   // Busy must cover five cycles even when the request is held on.
   task automatic busy_chk(input int hold, input logic burst);
      int n;
      n = 0;
      ctrl.fire(hold, burst);
      while (pulse_busy_reg === 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
      checked++;
      if (n != 6 - hold) begin
         errors++;
         $display("[ERR] busy cycles expected %0d seen %0d", 6 - hold, n);
      end
   endtask

   // A loaded column stays hidden until a pulse; bad frames open nothing.
   task automatic rewrite_chk;
      ctrl.load_col(911, 1'b1);
      arr(911, 1'b0);
      ctrl.frame(912, 10);
      ctrl.frame(0, 9);
      repeat (4) begin
         @(negedge mclk);
      end
      chk("col_open_reg", 1'b0, col_open_reg);
      ctrl.beats(0, 1'b1);
      busy_chk(3, 1'b1);
      arr(911, 1'b1);
      arr(0, 1'b0);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence; every column is loaded before the first pulse.
   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      park = 1'b0;
      q_col = '0;
      q_row = '0;
      errors = 0;
      checked = 0;
      cycles = 0;
      repeat (10) begin
         @(negedge mclk);
      end
      sys_rst = 1'b0;
      border_chk();
      for (int c = 0; c < COLS; c++) begin
         ctrl.load_col(c, 1'b0);
      end
      chk("col_open missed", 1'b0, missed);
      q(465, 600, 1'b0, 1'b0, 1'b0);
      busy_chk(1, 1'b0);
      arr(0, 1'b0);
      arr(455, 1'b0);
      arr(911, 1'b0);
      rewrite_chk();
      park = 1'b1;
      @(negedge mclk);
      q(465, 600, 1'b0, 1'b0, 1'b0);
      park = 1'b0;
      border_chk();
      chk("ctrl missed", 1'b0, missed);
      tally_and_finish();
   end
endmodule
